//--- panel_pkg.sv
// constants for the panel pixel input: geometry, colour layout, frame state
// assumes a single 320x240 panel with 6-bit colour channels
package panel_pkg;
  localparam int CHAN_BITS    = 6;
  localparam int WORD_BITS    = 3 * CHAN_BITS;
  localparam int H_ACTIVE     = 320;
  localparam int V_ACTIVE     = 240;
  localparam int COLOURS      = 262144;
  localparam int COL_BITS     = 9;
  localparam int ROW_BITS     = 8;
  localparam int RED_LSB      = 12;
  localparam int GREEN_LSB    = 6;
  localparam int BLUE_LSB     = 0;
  localparam logic [COL_BITS-1:0] COL_LAST = 9'h13f;
  localparam logic [ROW_BITS-1:0] ROW_LAST = 8'hef;
  localparam logic [COL_BITS-1:0] COL_RESET = 9'h000;
  localparam logic [ROW_BITS-1:0] ROW_RESET = 8'h00;
  typedef enum logic [1:0] {WAIT_FRAME, IN_FRAME} frame_state_t;
endpackage

//--- level_sync.sv
// two-flop synchroniser for a single level
// assumes the input is asynchronous to clk
`timescale 1ns/1ns
module level_sync (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_state_t;
  sync_state_t st_reg;
  sync_state_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule

//--- rgb_panel_input_interface.sv
// panel pixel input: samples colour words on the dot clock, tracks pixel
// position with optional 180 degree rotation, and gates the backlight.
// assumes the host drives every input actively; dot clock is the link clock.
// Notes on behaviour
// - three six-bit channels per pixel, bit zero least significant.
// - image is 320 columns by 240 rows.
// - enable high marks valid data; its rise sets first column.
// - select high reverses columns and rows; low scans normally.
// - one pixel word drives one red-green-blue stripe dot group.
// - backlight lit while brightness input high and shutdown low, dark otherwise.
`timescale 1ns/1ns
module rgb_panel_input_interface
  import panel_pkg::*;
(
  input  wire logic                          clk_sys,
  input  wire logic                          arst_n,
  input  wire logic                          dot_clock,
  input  wire logic                          hsync_n,
  input  wire logic                          vsync_n,
  input  wire logic                          pixel_valid_enable,
  input  wire logic [panel_pkg::CHAN_BITS-1:0] red_channel_bits,
  input  wire logic [panel_pkg::CHAN_BITS-1:0] green_channel_bits,
  input  wire logic [panel_pkg::CHAN_BITS-1:0] blue_channel_bits,
  input  wire logic                          scan_direction_select,
  input  wire logic                          shutdown,
  input  wire logic                          brightness_pwm,
  output logic                               pixel_write,
  output logic [panel_pkg::COL_BITS-1:0]     pixel_col,
  output logic [panel_pkg::ROW_BITS-1:0]     pixel_row,
  output logic [panel_pkg::CHAN_BITS-1:0]    dot_red,
  output logic [panel_pkg::CHAN_BITS-1:0]    dot_green,
  output logic [panel_pkg::CHAN_BITS-1:0]    dot_blue,
  output logic                               frame_active,
  output logic                               shutdown_fault,
  output logic                               backlight_on
);
  import panel_pkg::*;

  // position after mirroring; used for both columns and rows
  function automatic logic [COL_BITS-1:0] mirror(
    input logic [COL_BITS-1:0] pos, input logic [COL_BITS-1:0] last,
    input logic rev);
    mirror = rev ? (last - pos) : pos;
  endfunction

  // link-side state, all on dot_clock
  typedef struct packed {
    logic                 en_d;
    logic                 vs_d;
    logic                 hs_d;
    logic                 rev;
    logic                 sel_s1;
    logic                 sel_s2;
    frame_state_t         fsm;
    logic                 line_seen;
    logic [COL_BITS-1:0]  col;
    logic [ROW_BITS-1:0]  row;
    logic                 wr;
    logic [COL_BITS-1:0]  out_col;
    logic [ROW_BITS-1:0]  out_row;
    logic [WORD_BITS-1:0] word;
    logic                 frame_tog;
  } link_state_t;
  link_state_t ls_reg;
  link_state_t ls_next;

  logic [WORD_BITS-1:0] in_word;

  // channels side by side, red high, blue low
  assign in_word = {red_channel_bits, green_channel_bits,
                    blue_channel_bits};

  always_comb begin
    logic [COL_BITS-1:0] c;
    logic [ROW_BITS-1:0] r;
    logic [COL_BITS-1:0] row_full;
    c              = COL_RESET;
    r              = ROW_RESET;
    row_full       = {1'b0, ROW_RESET};
    ls_next        = ls_reg;
    ls_next.en_d   = pixel_valid_enable;
    ls_next.vs_d   = vsync_n;
    ls_next.hs_d   = hsync_n;
    ls_next.sel_s1 = scan_direction_select;
    ls_next.sel_s2 = ls_reg.sel_s1;
    ls_next.wr     = 1'b0;
    case (ls_reg.fsm)
      WAIT_FRAME: begin
        // falling vsync starts a frame; direction latched per frame so
        // a mid-frame change cannot tear the image
        if (ls_reg.vs_d && !vsync_n) begin
          ls_next.fsm       = IN_FRAME;
          ls_next.row       = ROW_RESET;
          ls_next.col       = COL_RESET;
          ls_next.line_seen = 1'b0;
          ls_next.rev       = ls_reg.sel_s2;
          ls_next.frame_tog = ~ls_reg.frame_tog;
        end
      end
      IN_FRAME: begin
        if (ls_reg.vs_d && !vsync_n) begin
          ls_next.row       = ROW_RESET;
          ls_next.col       = COL_RESET;
          ls_next.line_seen = 1'b0;
          ls_next.rev       = ls_reg.sel_s2;
          ls_next.frame_tog = ~ls_reg.frame_tog;
        end else begin
          // enable rise fixes column zero of a new line
          if (pixel_valid_enable && !ls_reg.en_d) begin
            ls_next.col = COL_RESET;
            if (ls_reg.line_seen && ls_reg.row != ROW_LAST) begin
              ls_next.row = ls_reg.row + 8'h01;
            end
          end
          if (pixel_valid_enable) begin
            c = (!ls_reg.en_d) ? COL_RESET : ls_reg.col;
            r = ls_next.row;
            // rows mirrored at column width, then cut back to row width
            row_full = mirror({1'b0, r}, {1'b0, ROW_LAST}, ls_reg.rev);
            // extra enabled cycles past column 319 are dropped
            if (c <= COL_LAST) begin
              ls_next.wr      = 1'b1;
              ls_next.out_col = mirror(c, COL_LAST, ls_reg.rev);
              ls_next.out_row = row_full[ROW_BITS-1:0];
              ls_next.word    = in_word;
              ls_next.col     = c + 9'h001;
              ls_next.line_seen = 1'b1;
            end
          end
        end
      end
      default: begin
        ls_next.fsm = WAIT_FRAME;
      end
    endcase
  end

  always_ff @(posedge dot_clock or negedge arst_n) begin
    if (!arst_n) begin
      ls_reg        <= '0;
      ls_reg.en_d   <= 1'b0;
      ls_reg.vs_d   <= 1'b1;
      ls_reg.hs_d   <= 1'b1;
      ls_reg.fsm    <= WAIT_FRAME;
    end else begin
      ls_reg <= ls_next;
    end
  end

  // pixel outputs stay in the link domain: they form the dot-group stream
  assign pixel_write = ls_reg.wr;
  assign pixel_col   = ls_reg.out_col;
  assign pixel_row   = ls_reg.out_row;
  assign dot_red     = ls_reg.word[RED_LSB +: CHAN_BITS];
  assign dot_green   = ls_reg.word[GREEN_LSB +: CHAN_BITS];
  assign dot_blue    = ls_reg.word[BLUE_LSB +: CHAN_BITS];

  // system-side state
  typedef struct packed {
    logic tog_d;
    logic active;
    logic fault;
    logic lamp;
  } sys_state_t;
  sys_state_t ss_reg;
  sys_state_t ss_next;

  logic tog_sync;
  logic shut_sync;
  logic pwm_sync;

  level_sync u_tog (.clk(clk_sys), .arst_n(arst_n),
                    .d(ls_reg.frame_tog), .q(tog_sync));
  level_sync u_shut (.clk(clk_sys), .arst_n(arst_n),
                     .d(shutdown), .q(shut_sync));
  level_sync u_pwm (.clk(clk_sys), .arst_n(arst_n),
                    .d(brightness_pwm), .q(pwm_sync));

  always_comb begin
    ss_next       = ss_reg;
    ss_next.tog_d = tog_sync;
    if (tog_sync != ss_reg.tog_d) begin
      ss_next.active = 1'b1;
    end
    // shutdown must stay grounded; fault follows the synchronised level, clears when low
    ss_next.fault = shut_sync;
    ss_next.lamp  = pwm_sync && !shut_sync;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ss_reg <= '0;
    end else begin
      ss_reg <= ss_next;
    end
  end

  assign frame_active   = ss_reg.active;
  assign shutdown_fault = ss_reg.fault;
  assign backlight_on   = ss_reg.lamp;

  a_lamp_follow: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    ss_reg.lamp |-> !ss_reg.fault)
    else $error("backlight lit during shutdown");
  a_col_range: assert property (
    @(posedge dot_clock) disable iff (!arst_n)
    ls_reg.wr |-> ls_reg.out_col <= COL_LAST)
    else $error("column beyond panel");
  a_row_range: assert property (
    @(posedge dot_clock) disable iff (!arst_n)
    ls_reg.wr |-> ls_reg.out_row <= ROW_LAST)
    else $error("row beyond panel");
  a_first_col: assert property (
    @(posedge dot_clock) disable iff (!arst_n)
    (ls_reg.fsm == IN_FRAME && vsync_n && pixel_valid_enable &&
     !ls_reg.en_d) |=>
    pixel_write && pixel_col == mirror(COL_RESET, COL_LAST, ls_reg.rev))
    else $error("line did not start at first column");
  a_step_col: assert property (
    @(posedge dot_clock) disable iff (!arst_n)
    (pixel_write && $past(pixel_valid_enable) && pixel_valid_enable &&
     vsync_n && ls_reg.vs_d && ls_reg.col <= COL_LAST) |=>
    pixel_write)
    else $error("enabled cycle did not advance");
  a_word_pass: assert property (
    @(posedge dot_clock) disable iff (!arst_n)
    pixel_write |-> {dot_red, dot_green, dot_blue} == $past(in_word))
    else $error("dot group does not match sampled word");
  a_no_enable: assert property (
    @(posedge dot_clock) disable iff (!arst_n)
    !pixel_valid_enable |=> !pixel_write)
    else $error("write without enable");
  a_dir_hold: assert property (
    @(posedge dot_clock) disable iff (!arst_n)
    !(ls_reg.vs_d && !vsync_n) |=> $stable(ls_reg.rev))
    else $error("direction changed inside frame");
endmodule

//--- host_model.sv
// host model: dot clock, syncs, enable and colour words for the panel input
// assumes the bench calls its tasks; every output is driven at all times
`timescale 1ns/1ns
module host_model (
  output logic       dot_clock,
  output logic       hsync_n,
  output logic       vsync_n,
  output logic       pixel_valid_enable,
  output logic [5:0] red_channel_bits,
  output logic [5:0] green_channel_bits,
  output logic [5:0] blue_channel_bits,
  output logic       scan_direction_select
);
  logic [17:0] word = 18'h15555; // never left floating
  assign {red_channel_bits, green_channel_bits, blue_channel_bits} = word;
  initial begin
    dot_clock = 1'b0;
    hsync_n = 1'b1;
    vsync_n = 1'b1;
    pixel_valid_enable = 1'b0;
    scan_direction_select = 1'b0;
    #37;
    // free-running, as panel hosts keep it going through blanking
    forever begin
      #62 dot_clock = 1'b1;
      #63 dot_clock = 1'b0;
    end
  end
  task automatic start_frame(input logic rev);
    @(negedge dot_clock);
    scan_direction_select = rev;
    repeat (4) @(negedge dot_clock);
    vsync_n = 1'b0;
    @(negedge dot_clock);
    vsync_n = 1'b1;
  endtask
  task automatic send_line(input int n);
    @(negedge dot_clock);
    hsync_n = 1'b0;
    @(negedge dot_clock);
    hsync_n = 1'b1;
    for (int k = 0; k < n; k++) begin
      pixel_valid_enable = 1'b1;
      word = {k[5:0], ~k[5:0], k[5:0] ^ 6'h2a};
      @(negedge dot_clock);
    end
    pixel_valid_enable = 1'b0;
    word = ~word; // idle data never repeats the last word
    repeat (3) @(negedge dot_clock);
  endtask
endmodule

//--- test_rgb_panel_input_interface.sv
// testbench for the panel pixel input
// assumes host_model drives the link; bench drives the clk_sys side
`timescale 1ns/1ns
module test_rgb_panel_input_interface;
  import panel_pkg::*;
  logic clk_sys = 1'b0, arst_n = 1'b0, shutdown = 1'b0, brightness_pwm = 1'b0;
  logic dot_clock, hsync_n, vsync_n, pixel_valid_enable, sel, pixel_write;
  logic [CHAN_BITS-1:0] red, green, blue, dot_red, dot_green, dot_blue;
  logic [COL_BITS-1:0] pixel_col;
  logic [ROW_BITS-1:0] pixel_row;
  logic frame_active, shutdown_fault, backlight_on, exp_rev = 1'b0;
  logic [17:0] exp_col, exp_pos_row, exp_dots;
  int fail_count = 0, check_count = 0, k = 0, writes = 0, exp_row = 0;
  always #50 clk_sys = ~clk_sys;
  host_model HOST (.dot_clock(dot_clock), .hsync_n(hsync_n),
    .vsync_n(vsync_n), .pixel_valid_enable(pixel_valid_enable),
    .red_channel_bits(red), .green_channel_bits(green),
    .blue_channel_bits(blue), .scan_direction_select(sel));
  rgb_panel_input_interface DUT (.clk_sys(clk_sys), .arst_n(arst_n),
    .dot_clock(dot_clock), .hsync_n(hsync_n), .vsync_n(vsync_n),
    .pixel_valid_enable(pixel_valid_enable), .red_channel_bits(red),
    .green_channel_bits(green), .blue_channel_bits(blue),
    .scan_direction_select(sel), .shutdown(shutdown),
    .brightness_pwm(brightness_pwm), .pixel_write(pixel_write),
    .pixel_col(pixel_col), .pixel_row(pixel_row), .dot_red(dot_red),
    .dot_green(dot_green), .dot_blue(dot_blue),
    .frame_active(frame_active), .shutdown_fault(shutdown_fault),
    .backlight_on(backlight_on));
  task automatic check(input string what, input logic [17:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(negedge dot_clock) if (pixel_write === 1'b1) begin
    exp_col = exp_rev ? 18'(H_ACTIVE-1-k) : 18'(k);
    exp_pos_row = exp_rev ? 18'(V_ACTIVE-1-exp_row) : 18'(exp_row);
    exp_dots = {6'(k), ~6'(k), 6'(k) ^ 6'h2a};
    check("col", 18'(pixel_col), exp_col);
    check("row", 18'(pixel_row), exp_pos_row);
    check("colour", {dot_red, dot_green, dot_blue}, exp_dots);
    k++;
    writes++;
  end
  task automatic t_refused;
    HOST.send_line(3);
    check("early writes", 18'(writes), 18'h00000);
    check("frame idle", 18'(frame_active), 18'h00000);
  endtask
  task automatic t_normal;
    HOST.start_frame(1'b0);
    HOST.send_line(4);
    check("line one writes", 18'(writes), 18'h00004);
    exp_row = 1;
    k = 0;
    HOST.send_line(4);
    check("line two writes", 18'(writes), 18'h00008);
    check("frame seen", 18'(frame_active), 18'h00001);
  endtask
  task automatic t_reversed_full;
    HOST.start_frame(1'b1);
    exp_rev = 1'b1;
    exp_row = 0;
    k = 0;
    writes = 0;
    HOST.send_line(H_ACTIVE + 2);
    check("full line writes", 18'(writes), 18'(H_ACTIVE));
  endtask
  task automatic t_backlight;
    @(negedge clk_sys) brightness_pwm = 1'b1; // supply up first
    check("lamp before", 18'(backlight_on), 18'h00000);
    repeat (4) @(negedge clk_sys);
    check("lamp lit", 18'(backlight_on), 18'h00001);
    shutdown = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("lamp shut", 18'(backlight_on), 18'h00000);
    check("fault", 18'(shutdown_fault), 18'h00001);
    shutdown = 1'b0;
    brightness_pwm = 1'b0;
    repeat (4) @(negedge clk_sys);
    check("lamp dark", 18'(backlight_on), 18'h00000);
    check("fault gone", 18'(shutdown_fault), 18'h00000);
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_refused();
    t_normal();
    t_reversed_full();
    t_backlight();
    stop_test();
  end
  initial begin
    #2000000;
    fail_count++;
    stop_test();
  end
endmodule
